// ### hdl/rsml_latch.sv
// Reset strap mode latch: samples mode straps as reset releases
//
// What this block does
// - Bus-style strap high at reset rise selects multiplexed external bus.
// - Bus-style strap low at reset rise selects separate address/data bus.
// - Byte-order strap high at reset rise selects big-endian ordering.
// - Byte-order strap low at reset rise selects little-endian ordering.
// - Flash-loader strap low at reset rise enters single boot mode.
// - Flash-loader strap high at reset rise starts normal operation.
// - Width straps high: loader high is single chip, low single boot.
`timescale 1ns/1ps

module rsml_latch
  import rsml_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       reset_pin_n,
  input  wire logic       bus_style_strap,
  input  wire logic       byte_order_strap,
  input  wire logic       flash_ldr_strap,
  input  wire logic [1:0] width_straps,
  output logic            bus_muxed,
  output logic            big_endian,
  output logic            single_boot,
  output logic            normal_start,
  output logic [1:0]      op_mode,
  output logic            mode_valid
);

  // All pins arrive asynchronously: five straps plus the reset pin
  localparam int NPIN = 6;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_clean;
  logic [NPIN-1:0] next_pin_clean;
  // Next values of the synchroniser stages
  logic [NPIN-1:0] next_sync1;
  logic [NPIN-1:0] next_sync2;
  logic [NPIN-1:0] next_sync3;

  assign pin_raw = {reset_pin_n, width_straps, flash_ldr_strap,
                    byte_order_strap, bus_style_strap};

  // Shift the pins along the chain; stage 1 has no other reader
  always_comb
  begin
    next_sync1 = pin_raw;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  // Three-stage synchroniser. The reset-pin bit starts at its idle high
  // level: a low start would fake a pin rise just after nrst and lock
  // whatever the straps show without any real reset pulse.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sync1 <= {1'h1, RST_WIDTH, RST_FLASH_LDR, RST_BYTE_ORDER,
                RST_BUS_STYLE};
      sync2 <= {1'h1, RST_WIDTH, RST_FLASH_LDR, RST_BYTE_ORDER,
                RST_BUS_STYLE};
      sync3 <= {1'h1, RST_WIDTH, RST_FLASH_LDR, RST_BYTE_ORDER,
                RST_BUS_STYLE};
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  // Accept a change per bit only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_filt
      always_comb
      begin
        next_pin_clean[gi] = pin_clean[gi];
        if (sync2[gi] == sync3[gi])
          next_pin_clean[gi] = sync3[gi];
      end
    end
  endgenerate

  // Filtered pins, reset to their idle levels (reset pin high)
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      pin_clean <= {1'h1, RST_WIDTH, RST_FLASH_LDR, RST_BYTE_ORDER,
                    RST_BUS_STYLE};
    else
      pin_clean <= next_pin_clean;
  end

  // Filtered strap view and held copy one cycle back, so that the values
  // present a clock before the reset rise are the ones taken; the board
  // keeps them steady across that window, so either copy is good.
  logic       rst_pin;
  logic       rst_pin_d;
  logic [4:0] strap_now;
  logic [4:0] strap_d;
  logic       rise;
  logic       next_rst_pin_d;
  logic [4:0] next_strap_d;

  assign rst_pin   = pin_clean[5];
  assign strap_now = pin_clean[4:0];
  assign rise      = rst_pin && !rst_pin_d;

  // One-cycle history of the filtered pins
  always_comb
  begin
    next_rst_pin_d = rst_pin;
    next_strap_d   = strap_now;
  end

  // History starts at the idle level too, so no edge is seen at start-up;
  // only a real low then high on the pin can arm and lock the straps
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rst_pin_d <= 1'h1;
      strap_d   <= {RST_WIDTH, RST_FLASH_LDR, RST_BYTE_ORDER, RST_BUS_STYLE};
    end
    else
    begin
      rst_pin_d <= next_rst_pin_d;
      strap_d   <= next_strap_d;
    end
  end

  // Capture sequencer: arm while reset pin is low, lock on its rise
  rsml_state_t state;
  rsml_state_t next_state;
  logic        next_bus_muxed;
  logic        next_big_endian;
  logic        next_single_boot;
  logic        next_normal_start;
  logic [1:0]  next_op_mode;
  logic        next_mode_valid;

  always_comb
  begin
    next_state        = state;
    next_bus_muxed    = bus_muxed;
    next_big_endian   = big_endian;
    next_single_boot  = single_boot;
    next_normal_start = normal_start;
    next_op_mode      = op_mode;
    next_mode_valid   = mode_valid;
    case (state)
      RSML_ST_RESET:
      begin
        // Never sample before a low level has been seen on the pin
        if (!rst_pin)
          next_state = RSML_ST_ARMED;
      end
      RSML_ST_ARMED:
      begin
        if (rise)
        begin
          next_state        = RSML_ST_LOCKED;
          next_bus_muxed    = strap_d[0];
          next_big_endian   = strap_d[1];
          next_single_boot  = !strap_d[2];
          next_normal_start = strap_d[2];
          next_mode_valid   = 1'h1;
          // Mode decode only when both width straps are high
          if (strap_d[4:3] != WIDTH_ONCHIP)
            next_op_mode = RSML_MODE_OTHER;
          else if (strap_d[2])
            next_op_mode = RSML_MODE_SINGLE_CHIP;
          else
            next_op_mode = RSML_MODE_SINGLE_BOOT;
        end
      end
      RSML_ST_LOCKED:
      begin
        // Straps ignored; only a new reset-pin low re-arms
        if (!rst_pin)
        begin
          next_state      = RSML_ST_ARMED;
          next_mode_valid = 1'h0;
        end
      end
      default:
        next_state = RSML_ST_RESET;
    endcase
  end

  // Held mode outputs, straight from flops
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state        <= RSML_ST_RESET;
      bus_muxed    <= RST_BUS_STYLE;
      big_endian   <= RST_BYTE_ORDER;
      single_boot  <= !RST_FLASH_LDR;
      normal_start <= RST_FLASH_LDR;
      op_mode      <= RSML_MODE_SINGLE_CHIP;
      mode_valid   <= 1'h0;
    end
    else
    begin
      state        <= next_state;
      bus_muxed    <= next_bus_muxed;
      big_endian   <= next_big_endian;
      single_boot  <= next_single_boot;
      normal_start <= next_normal_start;
      op_mode      <= next_op_mode;
      mode_valid   <= next_mode_valid;
    end
  end

endmodule

// ### pkg/rsml_pkg.sv
// Constants and types for the reset strap mode latch
package rsml_pkg;

  // Strap reset values (defaults: separate bus, little, normal)
  localparam logic RST_BUS_STYLE  = 1'h0;
  localparam logic RST_BYTE_ORDER = 1'h0;
  localparam logic RST_FLASH_LDR  = 1'h1;
  localparam logic [1:0] RST_WIDTH = 2'h3;

  // Width strap pattern that selects the on-chip modes
  localparam logic [1:0] WIDTH_ONCHIP = 2'h3;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // Decoded operating mode
  typedef enum logic [1:0]
  {
    RSML_MODE_SINGLE_CHIP = 2'b00,
    RSML_MODE_SINGLE_BOOT = 2'b01,
    RSML_MODE_OTHER       = 2'b10
  } rsml_mode_t;

  // Capture sequencer states
  typedef enum logic [1:0]
  {
    RSML_ST_RESET  = 2'b00,
    RSML_ST_ARMED  = 2'b01,
    RSML_ST_LOCKED = 2'b10
  } rsml_state_t;

endpackage

// ### bench/rsml_checker.sv
// Assertions on the mode latch outputs
`timescale 1ns/1ps
module rsml_checker
  import rsml_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       reset_pin_n,
  input wire logic       bus_style_strap,
  input wire logic       byte_order_strap,
  input wire logic       flash_ldr_strap,
  input wire logic       mode_valid,
  input wire logic [1:0] width_straps,
  input wire logic [1:0] op_mode,
  input wire logic       bus_muxed,
  input wire logic       big_endian,
  input wire logic       single_boot,
  input wire logic       normal_start
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic       pin_q;
  logic [4:0] cap;
  // Straps as they stood at the pin rise; live pins may move after lock
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pin_q <= 1'h1;
      cap   <= 5'h00;
    end
    else
    begin
      pin_q <= reset_pin_n;
      if (reset_pin_n && !pin_q)
        cap <= {width_straps, flash_ldr_strap, byte_order_strap,
                bus_style_strap};
    end
  end
  sequence s_lock; $rose(mode_valid); endsequence
  sequence s_rel; !reset_pin_n [*8] ##1 reset_pin_n [*8]; endsequence
  property p_bus; s_lock |-> bus_muxed == cap[0]; endproperty
  a_bus: assert property (p_bus) else $error("bus");
  property p_end; s_lock |-> big_endian == cap[1]; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_boot; s_lock |-> single_boot == !cap[2]; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_norm; s_lock |-> normal_start == cap[2]; endproperty
  a_norm: assert property (p_norm) else $error("norm");
  property p_chip; s_lock ##0 cap[4:3] == WIDTH_ONCHIP |->
    op_mode == (cap[2] ? RSML_MODE_SINGLE_CHIP
    : RSML_MODE_SINGLE_BOOT); endproperty
  a_chip: assert property (p_chip) else $error("chip");
  // Once locked nothing moves until the next pin low
  property p_hold; mode_valid ##1 mode_valid |->
    $stable({bus_muxed, big_endian, single_boot, normal_start, op_mode});
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_lat; s_rel |-> mode_valid; endproperty
  a_lat: assert property (p_lat) else $error("late");
  property p_excl; mode_valid |-> normal_start != single_boot; endproperty
  a_excl: assert property (p_excl) else $error("excl");
endmodule
bind rsml_latch rsml_checker u_chk (.clk_sys, .nrst, .reset_pin_n,
  .bus_style_strap, .byte_order_strap, .flash_ldr_strap, .mode_valid,
  .width_straps, .op_mode, .bus_muxed, .big_endian, .single_boot,
  .normal_start);

// ### bench/rsml_board.sv
// Board straps and external reset source
`timescale 1ns/1ps
module rsml_board
(
  input  wire logic       clk_sys,
  output logic            reset_pin_n,
  output logic            bus_style_strap, byte_order_strap, flash_ldr_strap,
  output logic [1:0]      width_straps
);
  logic [4:0] straps = 5'h1F;
  // Pull-ups hold every strap high until set
  assign {width_straps, flash_ldr_strap, byte_order_strap,
    bus_style_strap} = straps;
  initial reset_pin_n = 1'h1;
  // Straps set at pin low and held long past the rise
  task automatic boot(input logic [4:0] s);
    @(negedge clk_sys);
    reset_pin_n = 1'h0;
    straps = s;
    repeat (8) @(negedge clk_sys);
    reset_pin_n = 1'h1;
  endtask
  // Late change while running
  task automatic wiggle();
    straps = ~straps;
  endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the reset strap mode latch
`timescale 1ns/1ps
module tb;
  import rsml_pkg::*;
  logic       clk_sys = 1'h0;
  logic       nrst = 1'h0;
  logic       reset_pin_n, bus_style_strap, byte_order_strap;
  logic       flash_ldr_strap, bus_muxed, big_endian, single_boot;
  logic       normal_start, mode_valid;
  logic [1:0] width_straps, op_mode;
  int         err_total = 0;
  int         num_checks = 0;
  always #2 clk_sys = ~clk_sys;
  rsml_board board (.clk_sys, .reset_pin_n, .bus_style_strap,
    .byte_order_strap, .flash_ldr_strap, .width_straps);
  rsml_latch dut (.clk_sys, .nrst, .reset_pin_n, .bus_style_strap,
    .byte_order_strap, .flash_ldr_strap, .width_straps, .bus_muxed,
    .big_endian, .single_boot, .normal_start, .op_mode, .mode_valid);
  // Compare and count
  task automatic chk(input string nm, input logic [1:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the lock; a timeout counts as a mismatch
  task automatic wait_lock(output logic ok);
    int n;
    n = 0;
    while (mode_valid !== 1'h1 && n < 30)
    begin
      @(negedge clk_sys);
      n++;
    end
    ok = (mode_valid === 1'h1);
    if (!ok)
      err_total++;
  endtask
  // One strap pattern, then a late wiggle that must be ignored
  task automatic run_one(input logic [4:0] s, output logic ok);
    logic [1:0] m;
    m = (s[4:3] != WIDTH_ONCHIP) ? RSML_MODE_OTHER : s[2] ?
      RSML_MODE_SINGLE_CHIP : RSML_MODE_SINGLE_BOOT;
    board.boot(s);
    wait_lock(ok);
    if (ok)
    begin
      board.wiggle();
      repeat (6) @(negedge clk_sys);
      chk("bus", {1'h0, s[0]}, {1'h0, bus_muxed});
      chk("endian", {1'h0, s[1]}, {1'h0, big_endian});
      chk("boot", {1'h0, !s[2]}, {1'h0, single_boot});
      chk("normal", {1'h0, s[2]}, {1'h0, normal_start});
      chk("mode", m, op_mode);
    end
  endtask
  // Every strap pattern, then a mid-run reset and one more boot
  initial
  begin
    logic ok;
    ok = 1'h1;
    repeat (6) @(negedge clk_sys);
    nrst = 1'h1;
    for (int i = 0; i < 32 && ok; i++)
      run_one(5'(i), ok);
    nrst = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("valid", 2'h0, {1'h0, mode_valid});
    chk("rst bus", {1'h0, RST_BUS_STYLE}, {1'h0, bus_muxed});
    chk("rst endian", {1'h0, RST_BYTE_ORDER}, {1'h0, big_endian});
    chk("rst boot", {1'h0, !RST_FLASH_LDR}, {1'h0, single_boot});
    chk("rst normal", {1'h0, RST_FLASH_LDR}, {1'h0, normal_start});
    chk("rst mode", RSML_MODE_SINGLE_CHIP, op_mode);
    nrst = 1'h1;
    // Pin stays high: no lock may appear without a pin low first
    repeat (8) @(negedge clk_sys);
    chk("no lock", 2'h0, {1'h0, mode_valid});
    if (ok)
      run_one(5'h1A, ok);
    results();
  end
endmodule
